// ---- hw/bstr_pkg.sv ----
// Constants, codes and cell map for the scan test data registers.
// Assumes the scan port controller lives outside and reports its state.
package bstr_pkg;

    localparam int CHAIN_LEN = 46;
    localparam int ID_LEN = 32;
    localparam int INSTR_LEN = 3;
    localparam int PAD_COUNT = 10;
    localparam int SYNC_WIDTH = 55;

    // Instruction codes
    localparam logic [2:0] INSTR_EXTEST = 3'h0;
    localparam logic [2:0] INSTR_IDCODE = 3'h1;
    localparam logic [2:0] INSTR_SAMPLE = 3'h2;
    localparam logic [2:0] INSTR_CLAMP = 3'h3;
    localparam logic [2:0] INSTR_HIGHZ = 3'h4;
    localparam logic [2:0] INSTR_BYPASS = 3'h7;

    // Identification word fields, values arbitrary
    localparam int ID_MFR_POS = 1;
    localparam int ID_PART_POS = 12;
    localparam int ID_VER_POS = 28;
    localparam logic [10:0] ID_MFR = 11'h2aa;
    localparam logic [15:0] ID_PART = 16'h5a3c;
    localparam logic [3:0] ID_VERSION = 4'h1;
    localparam logic [31:0] ID_WORD = {ID_VERSION, ID_PART, ID_MFR, 1'b1};

    // Reset values
    localparam logic [45:0] BSR_RESET = 46'h0;
    localparam logic [9:0] PAD_DATA_RESET = 10'h0;
    localparam logic [9:0] PAD_OE_N_RESET = 10'h3ff;

    // Control cells
    localparam int CTL_UPPER_BUS = 1;
    localparam int CTL_BUS0 = 3;
    localparam int CTL_IRQ = 15;
    localparam int CTL_TXSYNC = 26;

    // Pads: 0..7 mux bus lines, 8 interrupt request, 9 transmit frame sync
    localparam int PAD_IRQ = 8;
    localparam int PAD_TXSYNC = 9;

    function automatic int pad_cell(input int pad);
        if (pad == 0) begin
            return 2;
        end else if (pad == 1) begin
            return 0;
        end else if (pad < PAD_IRQ) begin
            return 47 - pad;
        end else if (pad == PAD_IRQ) begin
            return 14;
        end else begin
            return 25;
        end
    endfunction

    function automatic int pad_ctl(input int pad);
        if (pad == 0) begin
            return CTL_BUS0;
        end else if (pad < PAD_IRQ) begin
            return CTL_UPPER_BUS;
        end else if (pad == PAD_IRQ) begin
            return CTL_IRQ;
        end else begin
            return CTL_TXSYNC;
        end
    endfunction

endpackage

// ---- hw/bstr_dr_if.sv ----
// Strobes and data between the chain owner and the identification register.
// Assumes one clock; tick strobes are single-cycle enables, capture, shift, update, tlr and sel are levels.
`timescale 1ns/10ps
`default_nettype none
interface bstr_dr_if;
    logic tick_rise;
    logic tick_fall;
    logic capture;
    logic shift;
    logic update;
    logic tlr;
    logic sel;
    logic sdi;
    logic sdo;
    logic [31:0] latched;

    modport owner (output tick_rise, tick_fall, capture, shift, update, tlr, sel, sdi,
                   input sdo, latched);
    modport idreg (input tick_rise, tick_fall, capture, shift, update, tlr, sel, sdi,
                   output sdo, latched);
endinterface
`default_nettype wire

// ---- hw/bstr_idreg.sv ----
// Identification register: shift path and latched parallel word.
// Assumes strobes already synchronised and edge-detected by the owner.
`timescale 1ns/10ps
`default_nettype none
module bstr_idreg (
    input wire logic clk,
    input wire logic rst,
    bstr_dr_if.idreg dr
);
    import bstr_pkg::*;

    logic [31:0] id_shift;

    ////////////////////////////////////////////////////////////////
    // Shift path
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            id_shift <= 32'h0;
        end else if (dr.tick_rise && dr.sel && dr.capture) begin
            id_shift <= ID_WORD; // [RULE10] [RULE9] [RULE5]
        end else if (dr.tick_rise && dr.sel && dr.shift) begin
            id_shift <= {dr.sdi, id_shift[31:1]}; // [RULE2] [RULE10]
        end
    end

    ////////////////////////////////////////////////////////////////
    // Latched word, untouched by shifting
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            dr.latched <= ID_WORD;
        end else if (dr.tlr) begin
            dr.latched <= ID_WORD; // [RULE3]
        end else if (dr.tick_fall && dr.sel && dr.update) begin
            dr.latched <= id_shift; // [RULE2]
        end
    end

    assign dr.sdo = id_shift[0];

    ////////////////////////////////////////////////////////////////
    // Checks
    chk_id_capture_word: assert property (@(posedge clk) disable iff (rst) // [RULE10]
        (dr.tick_rise && dr.sel && dr.capture) |=> (id_shift == ID_WORD && id_shift[0] == 1'b1))
        else $error("id capture did not load the identification word");
    chk_id_latch_stable: assert property (@(posedge clk) disable iff (rst) // [RULE2]
        (dr.shift && !dr.update && !dr.tlr) |=> $stable(dr.latched))
        else $error("id latched word changed while shifting");
endmodule // bstr_idreg
`default_nettype wire

// ---- hw/bstr_top.sv ----
// Scan test data registers: bypass, identification and boundary chain.
// Assumes an outside scan port controller reporting its state on pins.
//
// What this block does
// RULE1: one-stage bypass for bypass, clamp, highz
// RULE2: id register has shift path plus latch
// RULE3: id selected under idcode and logic reset
// RULE4: boundary chain has shift path plus latch
// RULE5: fixed sixteen-bit part identifier, never altered
// RULE6: cells 0-45; observe cells only capture
// RULE7: control cells 1,3,15,26 enable output cells
// RULE8: three-bit instruction codes select data registers
// RULE9: id word: lsb one, mfr, part, version
// RULE10: idcode captures word, then shifts it out
// RULE11: cell 0 nearest output, 45 nearest input
`timescale 1ns/10ps
`default_nettype none
module bstr_top (
    input wire logic clk,
    input wire logic rst,
    input wire logic scan_clock,
    input wire logic scan_serial_in,
    input wire logic tap_capture_dr,
    input wire logic tap_shift_dr,
    input wire logic tap_update_dr,
    input wire logic tap_logic_reset,
    input wire logic [bstr_pkg::INSTR_LEN-1:0] current_instr,
    input wire logic [bstr_pkg::CHAIN_LEN-1:0] pin_level,
    input wire logic [bstr_pkg::PAD_COUNT-1:0] core_pad_data,
    input wire logic [bstr_pkg::PAD_COUNT-1:0] core_pad_drive,
    output logic scan_serial_out,
    output logic scan_serial_out_en_n,
    output logic [bstr_pkg::PAD_COUNT-1:0] pad_data,
    output logic [bstr_pkg::PAD_COUNT-1:0] pad_oe_n
);
    import bstr_pkg::*;

    logic [SYNC_WIDTH-1:0] sync_a;
    logic [SYNC_WIDTH-1:0] sync_b;
    logic sclk_d;
    logic sclk_s;
    logic sdi_s;
    logic cap_s;
    logic shf_s;
    logic upd_s;
    logic tlr_s;
    logic [2:0] instr_s;
    logic [45:0] pins_s;
    logic rise;
    logic fall;
    logic sel_id;
    logic sel_bsr;
    logic sel_byp;
    logic test_drive;
    logic test_hz;
    logic bypass_bit;
    logic [45:0] bsr_shift;
    logic [45:0] bsr_latch;
    logic [45:0] cap_vec;
    logic next_sdo;
    logic [9:0] next_pad_data;
    logic [9:0] next_pad_oe_n;

    bstr_dr_if dr_bus ();

    ////////////////////////////////////////////////////////////////
    // Two-stage synchroniser for everything from the pins
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            sync_a <= 55'h0;
            sync_b <= 55'h0;
        end else begin
            sync_a <= {scan_clock, scan_serial_in, tap_capture_dr, tap_shift_dr,
                       tap_update_dr, tap_logic_reset, current_instr, pin_level};
            sync_b <= sync_a;
        end
    end

    assign {sclk_s, sdi_s, cap_s, shf_s, upd_s, tlr_s, instr_s, pins_s} = sync_b;

    // Scan clock edge finder
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            sclk_d <= 1'b0;
        end else begin
            sclk_d <= sclk_s;
        end
    end

    assign rise = sclk_s && !sclk_d;
    assign fall = !sclk_s && sclk_d;

    ////////////////////////////////////////////////////////////////
    // Instruction decode
    always_comb begin
        sel_id = 1'b0;
        sel_bsr = 1'b0;
        sel_byp = 1'b0;
        test_drive = 1'b0;
        test_hz = 1'b0;
        if (tlr_s) begin
            sel_id = 1'b1; // [RULE3]
        end else begin
            case (instr_s) // [RULE8]
                INSTR_EXTEST: begin
                    sel_bsr = 1'b1;
                    test_drive = 1'b1;
                end
                INSTR_SAMPLE: sel_bsr = 1'b1;
                INSTR_IDCODE: sel_id = 1'b1; // [RULE3]
                INSTR_CLAMP: begin
                    sel_byp = 1'b1; // [RULE1]
                    test_drive = 1'b1;
                end
                INSTR_HIGHZ: begin
                    sel_byp = 1'b1; // [RULE1]
                    test_hz = 1'b1;
                end
                default: sel_byp = 1'b1; // [RULE1]
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////
    // Bypass stage
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            bypass_bit <= 1'b0;
        end else if (rise && sel_byp && cap_s) begin
            bypass_bit <= 1'b0;
        end else if (rise && sel_byp && shf_s) begin
            bypass_bit <= sdi_s; // [RULE1]
        end
    end

    ////////////////////////////////////////////////////////////////
    // Boundary chain capture values: pins, or core enables at control cells
    always_comb begin
        cap_vec = pins_s; // [RULE6]
        cap_vec[CTL_UPPER_BUS] = core_pad_drive[1]; // [RULE7]
        cap_vec[CTL_BUS0] = core_pad_drive[0];
        cap_vec[CTL_IRQ] = core_pad_drive[PAD_IRQ];
        cap_vec[CTL_TXSYNC] = core_pad_drive[PAD_TXSYNC];
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            bsr_shift <= BSR_RESET;
        end else if (rise && sel_bsr && cap_s) begin
            bsr_shift <= cap_vec; // [RULE4] [RULE6]
        end else if (rise && sel_bsr && shf_s) begin
            bsr_shift <= {sdi_s, bsr_shift[45:1]}; // [RULE11]
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            bsr_latch <= BSR_RESET;
        end else if (fall && sel_bsr && upd_s) begin
            bsr_latch <= bsr_shift; // [RULE4]
        end
    end

    ////////////////////////////////////////////////////////////////
    // Identification register
    assign dr_bus.tick_rise = rise;
    assign dr_bus.tick_fall = fall;
    assign dr_bus.capture = cap_s;
    assign dr_bus.shift = shf_s;
    assign dr_bus.update = upd_s;
    assign dr_bus.tlr = tlr_s;
    assign dr_bus.sel = sel_id;
    assign dr_bus.sdi = sdi_s;

    bstr_idreg u_idreg (
        .clk(clk),
        .rst(rst),
        .dr(dr_bus.idreg)
    );

    ////////////////////////////////////////////////////////////////
    // Serial output, changes on the falling scan clock edge
    always_comb begin
        if (sel_id) begin
            next_sdo = dr_bus.sdo;
        end else if (sel_bsr) begin
            next_sdo = bsr_shift[0]; // [RULE11]
        end else begin
            next_sdo = bypass_bit; // [RULE1]
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            scan_serial_out <= 1'b0;
            scan_serial_out_en_n <= 1'b1;
        end else if (fall) begin
            scan_serial_out <= next_sdo;
            scan_serial_out_en_n <= !shf_s;
        end
    end

    ////////////////////////////////////////////////////////////////
    // Three-state output cells
    for (genvar p = 0; p < PAD_COUNT; p++) begin : g_pad
        always_comb begin
            if (test_hz) begin
                next_pad_data[p] = core_pad_data[p];
                next_pad_oe_n[p] = 1'b1;
            end else if (test_drive) begin
                next_pad_data[p] = bsr_latch[pad_cell(p)];
                next_pad_oe_n[p] = !bsr_latch[pad_ctl(p)]; // [RULE7]
            end else begin
                next_pad_data[p] = core_pad_data[p];
                next_pad_oe_n[p] = !core_pad_drive[p];
            end
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            pad_data <= PAD_DATA_RESET;
            pad_oe_n <= PAD_OE_N_RESET;
        end else begin
            pad_data <= next_pad_data;
            pad_oe_n <= next_pad_oe_n;
        end
    end

    ////////////////////////////////////////////////////////////////
    // Checks
    chk_bypass_one_stage: assert property (@(posedge clk) disable iff (rst) // [RULE1]
        (rise && sel_byp && shf_s && !cap_s) |=> (bypass_bit == $past(sdi_s)))
        else $error("bypass stage did not take the serial input");
    chk_chain_shift_dir: assert property (@(posedge clk) disable iff (rst) // [RULE11]
        (rise && sel_bsr && shf_s && !cap_s)
        |=> (bsr_shift[45] == $past(sdi_s) && bsr_shift[44:0] == $past(bsr_shift[45:1])))
        else $error("boundary chain shifted the wrong way");
    chk_observe_capture: assert property (@(posedge clk) disable iff (rst) // [RULE6]
        (rise && sel_bsr && cap_s) |=> (bsr_shift[39:27] == $past(pins_s[39:27])
                                       && bsr_shift[4] == $past(pins_s[4])))
        else $error("observe cell did not capture its pin");
    chk_chain_update: assert property (@(posedge clk) disable iff (rst) // [RULE4]
        (fall && sel_bsr && upd_s) |=> (bsr_latch == $past(bsr_shift)))
        else $error("boundary latch not updated");
    chk_latch_hold_shift: assert property (@(posedge clk) disable iff (rst) // [RULE4]
        (shf_s && !upd_s) |=> $stable(bsr_latch))
        else $error("boundary latch moved during shift");
    chk_highz_release: assert property (@(posedge clk) disable iff (rst) // [RULE8]
        (!tlr_s && instr_s == INSTR_HIGHZ) |=> (pad_oe_n == 10'h3ff))
        else $error("pads driven under highz");
    chk_ctl_enable_bus: assert property (@(posedge clk) disable iff (rst) // [RULE7]
        (!tlr_s && instr_s == INSTR_EXTEST)
        |=> (pad_oe_n[7:1] == {7{!$past(bsr_latch[CTL_UPPER_BUS])}}
             && pad_oe_n[0] == !$past(bsr_latch[CTL_BUS0])
             && pad_oe_n[PAD_IRQ] == !$past(bsr_latch[CTL_IRQ])
             && pad_oe_n[PAD_TXSYNC] == !$past(bsr_latch[CTL_TXSYNC])))
        else $error("output cell enable not from its control cell");
    chk_id_select: assert property (@(posedge clk) disable iff (rst) // [RULE3]
        (tlr_s || instr_s == INSTR_IDCODE) |-> (sel_id && !sel_bsr && !sel_byp))
        else $error("id register not selected");
    chk_sdo_follows: assert property (@(posedge clk) disable iff (rst) // [RULE10]
        (fall && sel_id) |=> (scan_serial_out == $past(dr_bus.sdo)))
        else $error("serial output not from id register");
endmodule // bstr_top
`default_nettype wire

// ---- verif/bstr_tester.sv ----
// Tester model: drives the test clock, TAP state levels and the instruction.
// Assumes the shared system clock; every change lands at its rising edge.
`timescale 1ns/10ps
`default_nettype none
module bstr_tester (
    input wire logic clk,
    input wire logic scan_serial_out,
    input wire logic scan_serial_out_en_n,
    output logic scan_clock,
    output logic scan_serial_in,
    output logic tap_capture_dr,
    output logic tap_shift_dr,
    output logic tap_update_dr,
    output logic tap_logic_reset,
    output logic [bstr_pkg::INSTR_LEN-1:0] current_instr
);
    initial begin
        scan_clock = 1'b0;
        scan_serial_in = 1'b0;
        tap_capture_dr = 1'b0;
        tap_shift_dr = 1'b0;
        tap_update_dr = 1'b0;
        tap_logic_reset = 1'b0;
        current_instr = 3'h0;
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Capture, n shifts, update; test clock 4 clk high, 4 clk low
    task automatic dr_scan(input logic [2:0] ins, input int n, input logic [63:0] din,
                           output logic [63:0] dout, output logic en_ok);
        dout = '0;
        en_ok = 1'b1;
        @(posedge clk);
        current_instr <= ins;
        tap_capture_dr <= 1'b1;
        repeat (4) @(posedge clk);
        for (int i = 0; i <= n; i++) begin
            scan_clock <= 1'b1;
            @(posedge clk);
            tap_capture_dr <= 1'b0;
            tap_shift_dr <= (i < n);
            tap_update_dr <= (i == n);
            scan_serial_in <= (i < n) ? din[i] : ~din[n-1];
            @(posedge clk);
            if (i > 0) begin
                dout[i-1] = scan_serial_out;
                en_ok &= (scan_serial_out_en_n === 1'b0);
            end
            repeat (2) @(posedge clk);
            scan_clock <= 1'b0;
            repeat (4) @(posedge clk);
        end
        tap_update_dr <= 1'b0;
    endtask

    // Test-logic-reset level, changed just after a clock edge
    task automatic set_tlr(input logic v);
        @(posedge clk);
        tap_logic_reset <= v;
    endtask
endmodule // bstr_tester
`default_nettype wire

// ---- verif/bstr_tb_top.sv ----
// Self-checking bench for the scan test data registers.
// Assumes bstr_pkg, the design files and the tester model compiled first.
`timescale 1ns/10ps
`default_nettype none
module bstr_tb_top;
    import bstr_pkg::*;
    typedef struct {logic [2:0] ins; int n; logic [63:0] din;} bstr_row_type;
    localparam logic [45:0] PAT = 46'h15a5_5a5a_8003;
    localparam int PAD_CELL [10] = '{2, 0, 45, 44, 43, 42, 41, 40, 14, 25};
    localparam int PAD_CTL [10] = '{3, 1, 1, 1, 1, 1, 1, 1, 15, 26};
    logic clk = 1'b0;
    logic rst = 1'b1;
    logic [45:0] pin_level = 46'h0;
    logic [9:0] core_pad_data = 10'h0;
    logic [9:0] core_pad_drive = 10'h0;
    logic scan_clock, scan_serial_in, tap_capture_dr, tap_shift_dr, tap_update_dr, tap_logic_reset;
    logic [2:0] current_instr;
    logic scan_serial_out, scan_serial_out_en_n;
    logic [9:0] pad_data, pad_oe_n;
    logic [45:0] lat = 46'h0;
    int miscompares = 0;
    int cmp_count = 0;
    bstr_row_type rows [9];

    always #12.5 clk = ~clk;

    bstr_top uut (.clk(clk), .rst(rst), .scan_clock(scan_clock), .scan_serial_in(scan_serial_in),
        .tap_capture_dr(tap_capture_dr), .tap_shift_dr(tap_shift_dr), .tap_update_dr(tap_update_dr),
        .tap_logic_reset(tap_logic_reset), .current_instr(current_instr), .pin_level(pin_level),
        .core_pad_data(core_pad_data), .core_pad_drive(core_pad_drive), .scan_serial_out(scan_serial_out),
        .scan_serial_out_en_n(scan_serial_out_en_n), .pad_data(pad_data), .pad_oe_n(pad_oe_n));

    bstr_tester u_tst (.clk(clk), .scan_serial_out(scan_serial_out),
        .scan_serial_out_en_n(scan_serial_out_en_n), .scan_clock(scan_clock), .scan_serial_in(scan_serial_in),
        .tap_capture_dr(tap_capture_dr), .tap_shift_dr(tap_shift_dr), .tap_update_dr(tap_update_dr),
        .tap_logic_reset(tap_logic_reset), .current_instr(current_instr));

    ////////////////////////////////////////////////////////////////////////////////
    task automatic check(input logic [63:0] got, input logic [63:0] exp, input string what);
        cmp_count++;
        if (got !== exp) begin
            miscompares++;
            $display("BAD %0t %s got %h exp %h", $time, what, got, exp);
        end
    endtask

    task automatic print_verdict();
        if (miscompares == 0 && cmp_count > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask

    // Serial word expected: captured contents first, then the bits fed in
    function automatic logic [63:0] exp_out(bstr_row_type r);
        logic [63:0] cap;
        cap = 64'(pin_level);
        cap[1] = core_pad_drive[1];
        cap[3] = core_pad_drive[0];
        cap[15] = core_pad_drive[8];
        cap[26] = core_pad_drive[9];
        case (r.ins)
            INSTR_SAMPLE, INSTR_EXTEST: exp_out = (r.din << 46) | cap;
            INSTR_IDCODE: exp_out = (r.din << 32) | 64'({ID_VERSION, ID_PART, ID_MFR, 1'b1});
            default: exp_out = r.din << 1;
        endcase
        exp_out &= (64'h1 << r.n) - 64'h1;
    endfunction

    task automatic check_pads(input logic [2:0] ins);
        logic [9:0] eoe;
        logic [9:0] edat;
        eoe = ~core_pad_drive;
        edat = core_pad_data;
        for (int p = 0; p < 10; p++) begin
            if (ins == INSTR_HIGHZ) eoe[p] = 1'b1;
            if (ins == INSTR_EXTEST || ins == INSTR_CLAMP) begin
                eoe[p] = ~lat[PAD_CTL[p]];
                edat[p] = lat[PAD_CELL[p]];
            end
        end
        check(64'(pad_oe_n), 64'(eoe), "pad enable");
        check(64'(pad_data & ~eoe), 64'(edat & ~eoe), "pad data");
    endtask

    task automatic run_row(input bstr_row_type r);
        logic [63:0] dout;
        logic en_ok;
        @(posedge clk);
        pin_level <= ~r.din[45:0];
        core_pad_drive <= r.din[9:0] ^ 10'h155;
        core_pad_data <= r.din[19:10];
        u_tst.dr_scan(r.ins, r.n, r.din, dout, en_ok);
        check(dout, exp_out(r), "scan data");
        check(64'(en_ok), 64'h1, "shift enable");
        if (r.ins == INSTR_SAMPLE || r.ins == INSTR_EXTEST) lat = r.din[53:8];
        repeat (4) @(posedge clk);
        check_pads(r.ins);
        check(64'(scan_serial_out_en_n), 64'h1, "idle enable");
    endtask

    ////////////////////////////////////////////////////////////////////////////////
    initial begin
        repeat (100000) @(posedge clk);
        miscompares++;
        print_verdict();
    end

    initial begin
        logic [63:0] dout;
        logic en_ok;
        rows = '{'{INSTR_SAMPLE, 54, {10'h0, PAT, 8'ha5}}, '{INSTR_IDCODE, 40, 64'h00c3_5a96_0f1e_2d3c},
                 '{INSTR_CLAMP, 9, 64'h1b5}, '{INSTR_HIGHZ, 9, 64'h0e6}, '{INSTR_BYPASS, 9, 64'h13c},
                 '{3'h5, 9, 64'h0a7}, '{3'h6, 9, 64'h159}, '{INSTR_EXTEST, 54, {10'h0, ~PAT, 8'h3c}},
                 '{INSTR_CLAMP, 9, 64'h0d2}};
        repeat (8) @(posedge clk);
        rst <= 1'b0;
        repeat (2) @(posedge clk);
        check_pads(INSTR_EXTEST);
        foreach (rows[i]) run_row(rows[i]);
        // Reset in mid-run clears the latch; id word survives
        @(posedge clk);
        rst <= 1'b1;
        repeat (3) @(posedge clk);
        check(64'({pad_oe_n, pad_data, scan_serial_out, scan_serial_out_en_n}), 64'h3ff001, "reset outputs");
        rst <= 1'b0;
        lat = 46'h0;
        run_row('{INSTR_CLAMP, 9, 64'h0d2});
        run_row('{INSTR_IDCODE, 32, 64'h0});
        // Test-logic-reset selects the id register over the instruction
        u_tst.set_tlr(1'b1);
        u_tst.dr_scan(INSTR_BYPASS, 32, 64'h0, dout, en_ok);
        check(dout, 64'(ID_WORD), "id under logic reset");
        check(64'(en_ok), 64'h1, "logic reset shift enable");
        repeat (4) @(posedge clk);
        check_pads(INSTR_BYPASS);
        u_tst.set_tlr(1'b0);
        print_verdict();
    end
endmodule // bstr_tb_top
`default_nettype wire
